/* File: egf_regs.svh */
// Offsets, field positions and reset values of the exposure/gain bank.
// Assumes a 32-bit AXI4-Lite data path; feature bit 0 is data bit 31.
`ifndef EGF_REGS_SVH
`define EGF_REGS_SVH

`define EGF_ADDR_W          12
`define EGF_EXPO_OFFSET     12'h81C
`define EGF_AMPL_OFFSET     12'h820
`define EGF_STATUS_OFFSET   12'h900

`define EGF_PRESENT_BIT     31
`define EGF_ABS_BIT         30
`define EGF_ONE_PUSH_BIT    26
`define EGF_ACTIVE_BIT      25
`define EGF_AUTO_BIT        24
`define EGF_VALUE_MSB       11
`define EGF_VALUE_LSB       0
`define EGF_VALUE_W         12
`define EGF_VALUE_RESET     12'h000

`define EGF_STAT_EXPO_REJ   0
`define EGF_STAT_AMPL_REJ   1
`define EGF_STAT_W          2

`endif

/* File: egf_pkg.sv */
// Types shared by the exposure/gain register bank.
// Assumes egf_regs.svh is on the include path.
`include "egf_regs.svh"

package egf_pkg;

  typedef enum logic [1:0]
  {
    EGF_RESP_OKAY   = 2'b00,
    EGF_RESP_SLVERR = 2'b10
  } egf_resp_t;

  typedef enum logic [1:0]
  {
    EGF_SEL_NONE   = 2'b00,
    EGF_SEL_EXPO   = 2'b01,
    EGF_SEL_AMPL   = 2'b10,
    EGF_SEL_STATUS = 2'b11
  } egf_sel_t;

  // Byte enables widened to the value field
  function automatic logic [`EGF_VALUE_W-1:0] egf_value_mask(input logic [3:0] strb);
    egf_value_mask = {{4{strb[1]}}, {8{strb[0]}}};
  endfunction : egf_value_mask

endpackage : egf_pkg

/* File: egf_feature_reg.sv */
// One feature control word: exposure time or amplification.
// Assumes the flag inputs come from logic on aclk.
`include "egf_regs.svh"

module egf_feature_reg
  import egf_pkg::*;
#(
  parameter bit                      PRESENT     = 1'b1,
  parameter logic [`EGF_VALUE_W-1:0] VALUE_RESET = `EGF_VALUE_RESET
)
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Write port from the bus slave
  input  wire logic                    wr_en,
  input  wire logic [31:0]             wr_data,
  input  wire logic [3:0]              wr_strb,
  // Feature state from the camera control logic
  input  wire logic                    feature_on,
  input  wire logic                    auto_mode,
  input  wire logic                    one_push_busy,
  // Results
  output logic      [31:0]             rd_word,
  output logic      [`EGF_VALUE_W-1:0] setting_value,
  output logic                         manual_apply,
  output logic                         wr_reject
);

  logic [`EGF_VALUE_W-1:0] value_q;
  logic [`EGF_VALUE_W-1:0] mask;
  logic                    accept;

  assign accept    = wr_en & feature_on;
  assign wr_reject = wr_en & ~feature_on;
  assign mask      = egf_value_mask(wr_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      value_q <= VALUE_RESET;
    else if (accept)
      value_q <= (value_q & ~mask) | (wr_data[`EGF_VALUE_MSB:`EGF_VALUE_LSB] & mask);
  end

  assign setting_value = value_q;
  // Abs source is never selectable, so local control always holds
  assign manual_apply  = PRESENT & feature_on & ~auto_mode;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_word[`EGF_PRESENT_BIT] = PRESENT;
    rd_word[`EGF_ABS_BIT] = 1'b0;
    rd_word[`EGF_ONE_PUSH_BIT] = one_push_busy & ~auto_mode;
    rd_word[`EGF_ACTIVE_BIT] = feature_on;
    rd_word[`EGF_AUTO_BIT] = auto_mode;
    rd_word[`EGF_VALUE_MSB:`EGF_VALUE_LSB] = value_q;
  end

endmodule : egf_feature_reg

/* File: egf_regs_top.sv */
// Exposure time and amplification control registers behind AXI4-Lite.
// Assumes one clock; flag inputs are produced by logic on aclk.
`include "egf_regs.svh"

// Summary of operation
// - Bit 0 (word MSB) reads one when the feature exists, zero otherwise.
// - Bit 1 picks source; zero uses local value, one the absolute register.
// - Absolute register absent, so the source bit is fixed and unwritable.
// - Bit 5 shows one-shot adjustment running; ignored while automatic mode.
// - Bit 6 reads one while the feature control is on.
// - While the feature is off, writes to all its fields are ignored.
// - Bit 7 reads zero for manual and one for automatic control.
// - Bits 20 to 31 hold the twelve-bit setting, applied under local control.
module egf_regs_top
  import egf_pkg::*;
#(
  parameter bit                      EXPO_PRESENT = 1'b1,
  parameter bit                      AMPL_PRESENT = 1'b1,
  parameter logic [`EGF_VALUE_W-1:0] EXPO_RESET   = `EGF_VALUE_RESET,
  parameter logic [`EGF_VALUE_W-1:0] AMPL_RESET   = `EGF_VALUE_RESET
)
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address
  input  wire logic [`EGF_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [`EGF_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Exposure feature state and setting
  input  wire logic                    expo_feature_on,
  input  wire logic                    expo_auto_mode,
  input  wire logic                    expo_one_push_busy,
  output logic [`EGF_VALUE_W-1:0]      expo_setting,
  output logic                         expo_manual_apply,
  // Amplification feature state and setting
  input  wire logic                    ampl_feature_on,
  input  wire logic                    ampl_auto_mode,
  input  wire logic                    ampl_one_push_busy,
  output logic [`EGF_VALUE_W-1:0]      ampl_setting,
  output logic                         ampl_manual_apply
);

  // Write channel holding registers
  logic                    aw_held_q;
  logic [`EGF_ADDR_W-1:0]  aw_addr_q;
  logic                    w_held_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic                    bvalid_q;
  egf_resp_t               bresp_q;

  // Read channel registers
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  egf_resp_t               rresp_q;

  // Sticky record of writes refused because a feature was off
  logic [`EGF_STAT_W-1:0]  reject_q;

  logic                    aw_fire;
  logic                    w_fire;
  logic                    ar_fire;
  logic                    wr_commit;
  egf_sel_t                wr_sel;
  egf_sel_t                rd_sel;
  logic                    expo_wr;
  logic                    ampl_wr;
  logic                    stat_wr;
  logic                    expo_reject;
  logic                    ampl_reject;
  logic [31:0]             expo_word;
  logic [31:0]             ampl_word;
  logic [31:0]             stat_word;
  logic                    expo_clear;
  logic                    ampl_clear;

  // Word-aligned decode; low two address bits are ignored
  function automatic egf_sel_t decode(input logic [`EGF_ADDR_W-1:0] addr);
    logic [`EGF_ADDR_W-1:0] expo_a;
    logic [`EGF_ADDR_W-1:0] ampl_a;
    logic [`EGF_ADDR_W-1:0] stat_a;
    expo_a = `EGF_EXPO_OFFSET;
    ampl_a = `EGF_AMPL_OFFSET;
    stat_a = `EGF_STATUS_OFFSET;
    if (addr[`EGF_ADDR_W-1:2] == expo_a[`EGF_ADDR_W-1:2])
      decode = EGF_SEL_EXPO;
    else if (addr[`EGF_ADDR_W-1:2] == ampl_a[`EGF_ADDR_W-1:2])
      decode = EGF_SEL_AMPL;
    else if (addr[`EGF_ADDR_W-1:2] == stat_a[`EGF_ADDR_W-1:2])
      decode = EGF_SEL_STATUS;
    else
      decode = EGF_SEL_NONE;
  endfunction : decode

  // Protection attributes are accepted and carry no meaning here
  // Address and data are held apart, so either may arrive first
  // Channels stall while a response waits, so only one write is open
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign aw_fire       = s_axi_awvalid & s_axi_awready;
  assign w_fire        = s_axi_wvalid & s_axi_wready;
  assign wr_commit     = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_sel        = decode(aw_addr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (aw_fire)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_commit)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (w_fire)
    begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_commit)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= EGF_RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_q <= 1'b1;
      // Unmapped writes end in an error and store nothing
      bresp_q  <= (wr_sel == EGF_SEL_NONE) ? EGF_RESP_SLVERR : EGF_RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Writes to read-only or refused fields still complete with OKAY
  assign expo_wr = wr_commit & (wr_sel == EGF_SEL_EXPO);
  assign ampl_wr = wr_commit & (wr_sel == EGF_SEL_AMPL);
  assign stat_wr = wr_commit & (wr_sel == EGF_SEL_STATUS) & w_strb_q[0];

  // Stored settings leave through flops inside each feature word
  egf_feature_reg #(
    .PRESENT       (EXPO_PRESENT),
    .VALUE_RESET   (EXPO_RESET)
  ) u_expo (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .wr_en         (expo_wr),
    .wr_data       (w_data_q),
    .wr_strb       (w_strb_q),
    .feature_on    (expo_feature_on),
    .auto_mode     (expo_auto_mode),
    .one_push_busy (expo_one_push_busy),
    .rd_word       (expo_word),
    .setting_value (expo_setting),
    .manual_apply  (expo_manual_apply),
    .wr_reject     (expo_reject)
  );

  egf_feature_reg #(
    .PRESENT       (AMPL_PRESENT),
    .VALUE_RESET   (AMPL_RESET)
  ) u_ampl (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .wr_en         (ampl_wr),
    .wr_data       (w_data_q),
    .wr_strb       (w_strb_q),
    .feature_on    (ampl_feature_on),
    .auto_mode     (ampl_auto_mode),
    .one_push_busy (ampl_one_push_busy),
    .rd_word       (ampl_word),
    .setting_value (ampl_setting),
    .manual_apply  (ampl_manual_apply),
    .wr_reject     (ampl_reject)
  );

  // Write-one-to-clear; a new refusal in the same cycle wins
  function automatic logic sticky_next(input logic held, input logic raise, input logic clear);
    sticky_next = raise | (held & ~clear);
  endfunction : sticky_next

  assign expo_clear = stat_wr & w_data_q[`EGF_STAT_EXPO_REJ];
  assign ampl_clear = stat_wr & w_data_q[`EGF_STAT_AMPL_REJ];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reject_q <= '0;
    else
    begin
      reject_q[`EGF_STAT_EXPO_REJ] <= sticky_next(reject_q[`EGF_STAT_EXPO_REJ], expo_reject,
                                                  expo_clear);
      reject_q[`EGF_STAT_AMPL_REJ] <= sticky_next(reject_q[`EGF_STAT_AMPL_REJ], ampl_reject,
                                                  ampl_clear);
    end
  end

  // Status bits above the refusal flags read zero
  assign stat_word = {30'h0000_0000, reject_q};

  // Read channel: one outstanding read, data one cycle after address
  assign s_axi_arready = ~rvalid_q;
  assign ar_fire       = s_axi_arvalid & s_axi_arready;
  assign rd_sel        = decode(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rvalid_q <= 1'b0;
    else if (ar_fire)
      rvalid_q <= 1'b1;
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= EGF_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      case (rd_sel)
        // feature words carry flags seen at the address edge
        EGF_SEL_EXPO:
        begin
          rdata_q <= expo_word;
          rresp_q <= EGF_RESP_OKAY;
        end
        EGF_SEL_AMPL:
        begin
          rdata_q <= ampl_word;
          rresp_q <= EGF_RESP_OKAY;
        end
        EGF_SEL_STATUS:
        begin
          rdata_q <= stat_word;
          rresp_q <= EGF_RESP_OKAY;
        end
        // Unmapped reads answer with an error and zero data
        default:
        begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= EGF_RESP_SLVERR;
        end
      endcase
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : egf_regs_top

/* File: egf_regs_sva.sv */
// Assertions on the exposure/gain register bank ports.
// Assumes it is bound to egf_regs_top; one clock, aclk.
module egf_regs_sva
#(
  parameter bit EXPO_PRESENT = 1'b1,
  parameter bit AMPL_PRESENT = 1'b1
)
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // Feature state
  input wire logic        expo_feature_on,
  input wire logic        expo_auto_mode,
  input wire logic [11:0] expo_setting,
  input wire logic        expo_manual_apply,
  input wire logic        ampl_feature_on,
  input wire logic        ampl_auto_mode,
  input wire logic [11:0] ampl_setting,
  input wire logic        ampl_manual_apply
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rd_reserved_a : assert property (s_axi_rvalid |-> s_axi_rdata[30:27] == 4'h0
    && s_axi_rdata[23:12] == 12'h000) else $error("reserved read bits set");
  oneshot_auto_a : assert property (s_axi_rvalid && s_axi_rdata[24] |-> !s_axi_rdata[26])
    else $error("one-shot flag shown in auto mode");
  flags_read_a : assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[11:2] == 10'h207 |=> s_axi_rdata[31] == EXPO_PRESENT
    && s_axi_rdata[25] == $past(expo_feature_on) && s_axi_rdata[24] == $past(expo_auto_mode))
    else $error("exposure flags misread");
  rd_answer_a : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_refuse_a : assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  wr_answer_a : assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  wr_refuse_a : assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  apply_a : assert property (expo_manual_apply == (EXPO_PRESENT && expo_feature_on
    && !expo_auto_mode) && ampl_manual_apply == (AMPL_PRESENT && ampl_feature_on
    && !ampl_auto_mode)) else $error("manual apply wrong");
  value_lock_a : assert property (!expo_feature_on |=> $stable(expo_setting))
    else $error("setting changed while feature off");
  ampl_lock_a : assert property (!ampl_feature_on |=> $stable(ampl_setting))
    else $error("amplification setting changed while feature off");

  cover property (s_axi_rvalid && s_axi_rdata[24]);
  cover property (s_axi_bvalid && !expo_feature_on);
  cover property (expo_manual_apply && ampl_manual_apply);
endmodule : egf_regs_sva

bind egf_regs_top egf_regs_sva #(.EXPO_PRESENT(EXPO_PRESENT), .AMPL_PRESENT(AMPL_PRESENT))
  i_egf_regs_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .expo_feature_on(expo_feature_on), .expo_auto_mode(expo_auto_mode),
  .expo_setting(expo_setting), .expo_manual_apply(expo_manual_apply),
  .ampl_feature_on(ampl_feature_on), .ampl_auto_mode(ampl_auto_mode),
  .ampl_setting(ampl_setting), .ampl_manual_apply(ampl_manual_apply));

/* File: egf_regs_top_tb.sv */
// Self-checking bench for the exposure/gain bank over AXI4-Lite.
// Assumes default parameters; bready and rready held high throughout.
`include "egf_regs.svh"
module egf_regs_top_tb import egf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awv, wv, arv;
  // Per feature: one-shot, on, auto; kept apart so a swap shows
  logic [2:0]  fg[2];
  logic        awr, wrdy, arr, bv, rv, ema, ama;
  logic [11:0] awa, ara, eset, aset;
  logic [31:0] wd, rdata, d;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  logic [33:0] q[$];
  logic [11:0] mv[2];
  int          num_errors, checks, cyc;

  egf_regs_top i_egf_regs_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .expo_feature_on(fg[0][1]),
    .expo_auto_mode(fg[0][0]), .expo_one_push_busy(fg[0][2]), .expo_setting(eset),
    .expo_manual_apply(ema), .ampl_feature_on(fg[1][1]), .ampl_auto_mode(fg[1][0]),
    .ampl_one_push_busy(fg[1][2]), .ampl_setting(aset), .ampl_manual_apply(ama));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] e);
    q.push_back({e, 32'h0});
    awa <= a;
    wd <= v;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (!bv);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    q.push_back(e);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
  endtask : rd

  // Flags land one edge before the next request
  task automatic fl(input logic [5:0] f);
    {fg[1], fg[0]} <= f;
    @(posedge aclk);
  endtask : fl

  function automatic logic [33:0] ew(input int k);
    return {EGF_RESP_OKAY, 2'b10, 3'b000, fg[k][2] & ~fg[k][0], fg[k][1], fg[k][0], 12'h000,
            mv[k]};
  endfunction : ew

  function automatic logic [11:0] ad(input int k);
    return k ? `EGF_AMPL_OFFSET : `EGF_EXPO_OFFSET;
  endfunction : ad

  // Readies are tied high, so each answer lasts one cycle
  always @(posedge aclk)
    if (aresetn && (rv || bv))
    begin
      if (q.size() == 0)
      begin
        num_errors++;
        $display("unexpected at %0t: answer %h with nothing pending", $time, rdata);
      end
      else chk(rv ? {rresp, rdata} : {bresp, 32'h0}, q.pop_front());
    end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  initial
  begin
    {aresetn, awv, wv, arv, fg[0], fg[1], awa, ara, wd, ws} = '0;
    mv[0] = `EGF_VALUE_RESET;
    mv[1] = `EGF_VALUE_RESET;
    void'($urandom(44793));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      fl({i[2:0], ~i[2:0]});
      for (int k = 0; k < 2; k++) rd(ad(k), ew(k));
    end
    fl(6'b010_010);
    for (int k = 0; k < 2; k++)
    begin
      d = $urandom | 32'h4000_0000;
      wr(ad(k), d, 4'hF, EGF_RESP_OKAY);
      mv[k] = d[11:0];
      rd(ad(k), ew(k));
    end
    chk({eset, aset, 8'h00, ema, ama}, {mv[0], mv[1], 10'h003});
    for (int s = 1; s < 16; s = s * 2)
    begin
      d = $urandom;
      wr(ad(0), d, s[3:0], EGF_RESP_OKAY);
      mv[0] = {s[1] ? d[11:8] : mv[0][11:8], s[0] ? d[7:0] : mv[0][7:0]};
      rd(ad(0), ew(0));
    end
    fl(6'b010_011);
    chk({32'h0, ema, ama}, 34'h1);
    fl(6'b000_000);
    for (int k = 0; k < 2; k++)
    begin
      wr(ad(k), $urandom, 4'hF, EGF_RESP_OKAY);
      rd(ad(k), ew(k));
    end
    rd(`EGF_STATUS_OFFSET, {EGF_RESP_OKAY, 32'h3});
    wr(`EGF_STATUS_OFFSET, 32'h1, 4'h1, EGF_RESP_OKAY);
    rd(`EGF_STATUS_OFFSET, {EGF_RESP_OKAY, 32'h2});
    wr(`EGF_STATUS_OFFSET, 32'h2, 4'h1, EGF_RESP_OKAY);
    rd(`EGF_STATUS_OFFSET, {EGF_RESP_OKAY, 32'h0});
    wr(12'h824, $urandom, 4'hF, EGF_RESP_SLVERR);
    rd(12'h824, {EGF_RESP_SLVERR, 32'h0});
    print_verdict();
  end
endmodule : egf_regs_top_tb
